//--- hdl/mdi_map_cfg.svh
/*
 Constants for the media pair crossover map: speed codes and reset values.
 Assumes inclusion by the map module only.
*/
`ifndef MDI_MAP_CFG_SVH
`define MDI_MAP_CFG_SVH
`define SPEED_CODE_10 2'h0
`define SPEED_CODE_100 2'h1
`define SPEED_CODE_1000 2'h2
`define MDIX_RESET 1'h0
`define SPEED_RESET 2'h0
`endif

//--- hdl/mdi_map_pkg.sv
/*
 Types for the media pair crossover map.
 Assumes a single clock domain; used by mdi_pair_crossover_map.
*/
package mdi_map_pkg;
   // One analog pin leg: what the channel drives and the enable of the driver.
   typedef struct packed {
      logic drive;
      logic drive_en;
   } leg_out_t;

   // One differential pair at the media side.
   typedef struct packed {
      leg_out_t pos;
      leg_out_t neg;
   } pair_out_t;

   typedef struct packed {
      logic pos;
      logic neg;
   } pair_in_t;

   typedef enum logic [1:0] {
      SPEED_10,
      SPEED_100,
      SPEED_1000,
      SPEED_RSVD
   } speed_t;
endpackage

//--- hdl/mdi_pair_crossover_map.sv
/*
 Maps four internal transceiver channels onto four media pin pairs,
 following MDI or MDI-X and the operating speed.
 Assumes select and speed are synchronous to ref_clk; the media legs are
 three-signal pins resolved by the analog front-end or testbench.
*/
`timescale 1ns/1ps
`include "mdi_map_cfg.svh"

// What this block does
// - Gigabit: pair B gets channel B, or A crossed
// - Slow speeds: pair B receives, or transmits crossed
// - Gigabit: pair C gets channel C, or D crossed
// - Gigabit: pair D gets channel D, or C crossed
// - Slow speeds: pairs C and D stay idle
// - Gigabit: pair A gets channel A, or B crossed
// - Slow speeds: pair A transmits, or receives crossed
module mdi_pair_crossover_map
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic mdix_sel,
   input wire logic [1:0] speed_sel,
   // Channel side: per channel a positive and negative leg to drive, and enable.
   input wire mdi_map_pkg::pair_out_t chan_tx [4],
   output mdi_map_pkg::pair_in_t chan_rx [4],
   // Media side: index 0..3 is pair A..D.
   input wire mdi_map_pkg::pair_in_t media_in [4],
   output mdi_map_pkg::pair_out_t media_out [4],
   output logic crossed,
   output logic gigabit
);
   import mdi_map_pkg::*;

   logic mdix_r;
   logic [1:0] speed_r;
   wire is_gig = (speed_r == `SPEED_CODE_1000);
   wire is_slow = (speed_r == `SPEED_CODE_10) || (speed_r == `SPEED_CODE_100);

   // Settings are registered so that all pairs in use swap on the same edge.
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         mdix_r <= `MDIX_RESET;
         speed_r <= `SPEED_RESET;
      end
      else
      begin
         mdix_r <= mdix_sel;
         speed_r <= speed_sel;
      end
   end

   // Channel feeding each pair: A<->B and C<->D swap when crossed.
   function automatic logic [1:0] src_chan(input logic [1:0] pair, input logic x);
      src_chan = x ? (pair ^ 2'h1) : pair;
   endfunction

   pair_out_t media_nxt [4];
   pair_in_t rx_nxt [4];

   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_pair
         wire [1:0] src = src_chan(2'(g), mdix_r);
         wire [1:0] dst = src_chan(2'(g), mdix_r);
         // At slow speed channel A transmits and channel B receives, so
         // pair A transmits in MDI and pair B does so in MDI-X.
         wire slow_tx = (g < 2) && (src == 2'h0);
         // Index g is a pair on the drive side and a channel on the receive side,
         // so only channel B may take receive data at slow speed.
         wire slow_rx = (g == 1);
         wire pass_tx = is_gig || (is_slow && slow_tx);
         wire pass_rx = is_gig || (is_slow && slow_rx);
         assign media_nxt[g] = pass_tx ? chan_tx[src] : '0;
         assign rx_nxt[g] = pass_rx ? media_in[dst] : '0;
         always_ff @(posedge ref_clk or negedge arst_n)
         begin
            if (!arst_n)
            begin
               media_out[g] <= '0;
               chan_rx[g] <= '0;
            end
            else
            begin
               media_out[g] <= media_nxt[g];
               chan_rx[g] <= rx_nxt[g];
            end
         end
      end
   endgenerate

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         crossed <= 1'b0;
         gigabit <= 1'b0;
      end
      else
      begin
         crossed <= mdix_r;
         gigabit <= is_gig;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   // Pair outputs follow the registered settings one edge later, so every
   // check except swap_follow_a and sel_reg_a compares against the settings and inputs of the previous edge.
   gig_pair_b_a: assert property (is_gig |=>
      media_out[1] == $past(mdix_r ? chan_tx[0] : chan_tx[1]))
      else $error("Pair B does not carry its gigabit channel.");
   gig_pair_c_a: assert property (is_gig && !mdix_r |=> media_out[2] == $past(chan_tx[2]))
      else $error("Pair C does not carry channel C in MDI.");
   gig_pair_d_a: assert property (is_gig && mdix_r |=> media_out[3] == $past(chan_tx[2]))
      else $error("Pair D does not carry channel C in MDI-X.");
   gig_pair_a_a: assert property (is_gig && mdix_r |=> media_out[0] == $past(chan_tx[1]))
      else $error("Pair A does not carry channel B in MDI-X.");
   slow_idle_cd_a: assert property (is_slow |=> media_out[2] == '0 && media_out[3] == '0
      && chan_rx[2] == '0 && chan_rx[3] == '0)
      else $error("Pair C or D active at slow speed.");
   slow_pair_b_a: assert property (is_slow && !mdix_r |=>
      chan_rx[1] == $past(media_in[1]) && media_out[1] == '0)
      else $error("Pair B is not the receive pair in MDI.");
   slow_pair_a_a: assert property (is_slow && mdix_r |=>
      chan_rx[1] == $past(media_in[0]) && media_out[0] == '0)
      else $error("Pair A is not the receive pair in MDI-X.");
   swap_follow_a: assert property ($changed(mdix_sel) |-> ##2 crossed == $past(mdix_sel, 2))
      else $error("Crossover indication did not follow the select.");

   // Remaining gigabit drive paths, the other order of each pair.
   gig_pair_c_x_a: assert property (is_gig && mdix_r |=>
      media_out[2] == $past(chan_tx[3]))
      else $error("Pair C does not carry channel D in MDI-X.");
   gig_pair_d_m_a: assert property (is_gig && !mdix_r |=>
      media_out[3] == $past(chan_tx[3]))
      else $error("Pair D does not carry channel D in MDI.");
   gig_pair_a_m_a: assert property (is_gig && !mdix_r |=>
      media_out[0] == $past(chan_tx[0]))
      else $error("Pair A does not carry channel A in MDI.");

   // Gigabit receive paths: each channel listens on the pair it drives.
   gig_rx_a_a: assert property (is_gig |=>
      chan_rx[0] == $past(mdix_r ? media_in[1] : media_in[0]))
      else $error("Channel A does not receive its gigabit pair.");
   gig_rx_b_a: assert property (is_gig |=>
      chan_rx[1] == $past(mdix_r ? media_in[0] : media_in[1]))
      else $error("Channel B does not receive its gigabit pair.");
   gig_rx_c_a: assert property (is_gig |=>
      chan_rx[2] == $past(mdix_r ? media_in[3] : media_in[2]))
      else $error("Channel C does not receive its gigabit pair.");
   gig_rx_d_a: assert property (is_gig |=>
      chan_rx[3] == $past(mdix_r ? media_in[2] : media_in[3]))
      else $error("Channel D does not receive its gigabit pair.");

   // Slow speed transmit pair in each order; the receive side stays quiet.
   slow_tx_a_a: assert property (is_slow && !mdix_r |=>
      media_out[0] == $past(chan_tx[0]) && chan_rx[0] == '0)
      else $error("Pair A is not the transmit pair in MDI.");
   slow_tx_b_a: assert property (is_slow && mdix_r |=>
      media_out[1] == $past(chan_tx[0]) && chan_rx[0] == '0)
      else $error("Pair B is not the transmit pair in MDI-X.");

   // Checks that the reserved speed code leaves every pair and channels A and B quiet.
   rsvd_idle_a: assert property (!is_gig && !is_slow |=>
      media_out[0] == '0 && media_out[1] == '0 && media_out[2] == '0
      && media_out[3] == '0 && chan_rx[0] == '0 && chan_rx[1] == '0)
      else $error("A pair is active at the reserved speed.");

   // A select flip is taken on one edge and, at gigabit, moves all four pairs on the next.
   sequence sel_taken;
      $changed(mdix_sel) ##1 $changed(mdix_r);
   endsequence
   sequence gig_cross_now;
      is_gig && mdix_r;
   endsequence
   sel_reg_a: assert property ($changed(mdix_sel) |-> sel_taken)
      else $error("Select change was not taken on the next edge.");
   swap_all_a: assert property ($changed(mdix_r) ##0 gig_cross_now |=>
      media_out[0] == $past(chan_tx[1]) && media_out[1] == $past(chan_tx[0])
      && media_out[2] == $past(chan_tx[3]) && media_out[3] == $past(chan_tx[2]))
      else $error("Pairs did not swap together on one edge.");
endmodule // mdi_pair_crossover_map

//--- test/cable_model.sv
/* Cable and far transceiver seen by the media pairs.
 Assumes the map's leg drives; far levels come from the bench. */
`timescale 1ns/1ps
module cable_model
(
   input wire mdi_map_pkg::pair_out_t media_out [4],
   input wire logic [7:0] far_lvl,
   output mdi_map_pkg::pair_in_t media_in [4]
);
   import mdi_map_pkg::*;
   // An enabled local leg wins; a released leg shows the far end.
   for (genvar p = 0; p < 4; p++)
   begin : g_leg
      assign media_in[p].pos = media_out[p].pos.drive_en ?
         media_out[p].pos.drive : far_lvl[2*p+1];
      assign media_in[p].neg = media_out[p].neg.drive_en ?
         media_out[p].neg.drive : far_lvl[2*p];
   end
endmodule // cable_model

//--- test/mdi_pair_crossover_map_tb.sv
/* Self-checking bench for the media pair crossover map.
 Assumes the cable model; a mode change shows two edges later. */
`timescale 1ns/1ps
module mdi_pair_crossover_map_tb;
   import mdi_map_pkg::*;
   logic ref_clk = 0;
   logic arst_n = 0;
   logic mdix_sel = 0;
   logic [1:0] speed_sel = 2'h0;
   logic crossed;
   logic gigabit;
   pair_out_t chan_tx [4] = '{4'hE, 4'hB, 4'hF, 4'h3};
   pair_in_t chan_rx [4];
   pair_in_t media_in [4];
   pair_out_t media_out [4];
   int fails = 0;
   int n_checks = 0;
   always #10 ref_clk = ~ref_clk;
   mdi_pair_crossover_map dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .mdix_sel(mdix_sel),
      .speed_sel(speed_sel), .chan_tx(chan_tx), .chan_rx(chan_rx), .media_in(media_in),
      .media_out(media_out), .crossed(crossed), .gigabit(gigabit));
   cable_model cable_u (.media_out(media_out), .far_lvl(8'h96), .media_in(media_in));
   task automatic chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Every speed code with both orders; pairs and channels all compared.
   task automatic sweep_modes();
      logic gig;
      logic use_p;
      for (int s = 0; s < 4; s++)
         for (int m = 0; m < 2; m++)
         begin
            mdix_sel = m[0];
            speed_sel = s[1:0];
            repeat (3) @(posedge ref_clk);
            #1;
            gig = (s == 2);
            chk("gigabit", {3'h0, gigabit}, {3'h0, gig});
            chk("crossed", {3'h0, crossed}, {3'h0, m[0]});
            for (int p = 0; p < 4; p++)
            begin
               use_p = gig || (s < 2 && p == m);
               chk("media_out", media_out[p], use_p ? chan_tx[p^m] : 4'h0);
               use_p = gig || (s < 2 && p == 1);
               chk("chan_rx", {2'h0, chan_rx[p]}, use_p ? {2'h0, media_in[p^m]} : 4'h0);
            end
         end
   endtask
   // One select flip from MDI-X to MDI at gigabit: all four pairs move on one edge.
   task automatic swap_b2b();
      speed_sel = 2'h2;
      mdix_sel = 1'h1;
      @(posedge ref_clk);
      #1;
      mdix_sel = 1'h0;
      @(posedge ref_clk);
      #1;
      for (int p = 0; p < 4; p++)
         chk("swap", media_out[p], chan_tx[p^1]);
      @(posedge ref_clk);
      #1;
      for (int p = 0; p < 4; p++)
         chk("unswap", media_out[p], chan_tx[p]);
   endtask
   initial
   begin
      repeat (20) @(posedge ref_clk);
      #1;
      arst_n = 1;
      sweep_modes();
      swap_b2b();
      report_and_stop();
   end
endmodule // mdi_pair_crossover_map_tb
